// ---- design/ds0_monitor_pkg.sv ----
package ds0_monitor_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] TX_MON_DATA_ADDR   = 8'h49;
  localparam logic [7:0] TX_MON_SELECT_ADDR = 8'hA8;
  localparam logic [7:0] RX_MON_SELECT_ADDR = 8'hAA;
  localparam logic [7:0] RX_MON_DATA_ADDR   = 8'hAB;
  localparam logic [7:0] SELECT_RESET       = 8'h00;
  localparam logic [7:0] MONITOR_RESET      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SEL_MSB        = 4;
  localparam int REMOTE_LOOP    = 7;
  localparam int LOCAL_LOOP     = 6;
  localparam int LINE_AIS       = 5;
  localparam int LINE_RESET     = 7;

  // ****************************************************************
  // Frame structure
  // ****************************************************************
  localparam int              BITS_PER_SLOT = 8;
  localparam int              SLOT_BITS     = 3;
  localparam int              CNT_W         = 8;
  localparam logic [2:0]      LAST_BIT      = 3'h7;
  localparam logic [7:0]      CNT_ONE       = 8'h01;
  localparam int              TX            = 0;
  localparam int              RX            = 1;

endpackage : ds0_monitor_pkg

// ---- design/ds0_channel_monitor.sv ----
// What this block does
// - Transmit selector bits 4..0 choose transmit channel
// - Receive selector bits 4..0 choose receive channel
// - Transmit monitor: first sent bit in bit7
// - Receive monitor: first received bit in bit7
// - Selector value is timeslot, channel minus one
// - Both directions monitored at once, independently
`timescale 1ns/10ps
`default_nettype none

module ds0_channel_monitor (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] bus_addr,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  input  wire logic [7:0] bus_wdata,
  output logic      [7:0] bus_rdata,
  input  wire logic       tx_line_data,
  input  wire logic       tx_bit_strobe,
  input  wire logic       tx_frame_sync,
  input  wire logic       rx_line_data,
  input  wire logic       rx_bit_strobe,
  input  wire logic       rx_frame_sync,
  output logic            remote_loop_enable,
  output logic            local_loop_enable,
  output logic            line_alarm_indication_enable,
  output logic            line_interface_reset_bit
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ****************************************************************
  // Control port registers
  // ****************************************************************
  logic [7:0] tx_sel_reg_q;
  logic [7:0] tx_sel_reg_d;
  logic [7:0] rx_sel_reg_q;
  logic [7:0] rx_sel_reg_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] mon_q [2];
  logic [4:0] sel   [2];

  always_comb begin
    tx_sel_reg_d = tx_sel_reg_q;
    rx_sel_reg_d = rx_sel_reg_q;
    rdata_d      = rdata_q;
    if (bus_wr && bus_addr == ds0_monitor_pkg::TX_MON_SELECT_ADDR) begin
      tx_sel_reg_d = bus_wdata;
    end else if (bus_wr && bus_addr == ds0_monitor_pkg::RX_MON_SELECT_ADDR) begin
      // Bits 6,5 are stored as written; software keeps them zero
      rx_sel_reg_d = bus_wdata;
    end
    if (bus_rd) begin
      if (bus_addr == ds0_monitor_pkg::TX_MON_DATA_ADDR) begin
        rdata_d = mon_q[ds0_monitor_pkg::TX];
      end else if (bus_addr == ds0_monitor_pkg::TX_MON_SELECT_ADDR) begin
        rdata_d = tx_sel_reg_q;
      end else if (bus_addr == ds0_monitor_pkg::RX_MON_SELECT_ADDR) begin
        rdata_d = rx_sel_reg_q;
      end else if (bus_addr == ds0_monitor_pkg::RX_MON_DATA_ADDR) begin
        rdata_d = mon_q[ds0_monitor_pkg::RX];
      end else begin
        rdata_d = ds0_monitor_pkg::UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_sel_reg_q <= ds0_monitor_pkg::SELECT_RESET;
      rx_sel_reg_q <= ds0_monitor_pkg::SELECT_RESET;
      rdata_q      <= ds0_monitor_pkg::UNMAPPED_READ;
    end else begin
      tx_sel_reg_q <= tx_sel_reg_d;
      rx_sel_reg_q <= rx_sel_reg_d;
      rdata_q      <= rdata_d;
    end
  end

  assign bus_rdata                    = rdata_q;
  assign remote_loop_enable           = tx_sel_reg_q[ds0_monitor_pkg::REMOTE_LOOP];
  assign local_loop_enable            = tx_sel_reg_q[ds0_monitor_pkg::LOCAL_LOOP];
  assign line_alarm_indication_enable = tx_sel_reg_q[ds0_monitor_pkg::LINE_AIS];
  assign line_interface_reset_bit     = rx_sel_reg_q[ds0_monitor_pkg::LINE_RESET];
  // Selector value is the timeslot number, i.e. channel number minus one
  assign sel[ds0_monitor_pkg::TX] = tx_sel_reg_q[ds0_monitor_pkg::SEL_MSB:0];
  assign sel[ds0_monitor_pkg::RX] = rx_sel_reg_q[ds0_monitor_pkg::SEL_MSB:0];

  // ****************************************************************
  // Per-direction line capture
  // ****************************************************************
  logic [2:0] pins [2];
  logic       stb  [2];
  logic [7:0] cnt_q [2];
  logic [7:0] idx  [2];
  logic       load [2];
  logic [7:0] word [2];

  assign pins[ds0_monitor_pkg::TX] = {tx_frame_sync, tx_bit_strobe, tx_line_data};
  assign pins[ds0_monitor_pkg::RX] = {rx_frame_sync, rx_bit_strobe, rx_line_data};

  // Each direction has its own counter and capture, so neither waits on the other
  for (genvar g = 0; g < 2; g++) begin : g_dir
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic       stb_old_q;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] cnt_d;
    logic [7:0] mon_d;

    // Line pins come from the framer's line clock, so they are resynchronised
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        s1_q      <= 3'h0;
        s2_q      <= 3'h0;
        stb_old_q <= 1'b0;
      end else begin
        s1_q      <= pins[g];
        s2_q      <= s1_q;
        stb_old_q <= s2_q[1];
      end
    end

    assign stb[g]  = s2_q[1] && !stb_old_q;
    assign idx[g]  = s2_q[2] ? 8'h00 : cnt_q[g];
    assign load[g] = stb[g] && idx[g] == {sel[g], ds0_monitor_pkg::LAST_BIT};
    // First bit on the line ends up in bit 7 after eight shifts
    assign word[g] = {shift_q[6:0], s2_q[0]};

    always_comb begin
      shift_d = shift_q;
      cnt_d   = cnt_q[g];
      mon_d   = mon_q[g];
      if (stb[g]) begin
        cnt_d = idx[g] + ds0_monitor_pkg::CNT_ONE;
        if (idx[g][ds0_monitor_pkg::CNT_W-1:ds0_monitor_pkg::SLOT_BITS] == sel[g]) begin
          shift_d = word[g];
        end
      end
      // Only a completed octet reaches the readable register
      if (load[g]) begin
        mon_d = word[g];
      end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        shift_q  <= 8'h00;
        cnt_q[g] <= 8'h00;
        mon_q[g] <= ds0_monitor_pkg::MONITOR_RESET;
      end else begin
        shift_q  <= shift_d;
        cnt_q[g] <= cnt_d;
        mon_q[g] <= mon_d;
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_tx_load;
    @(posedge core_clk) disable iff (!rst_sync_n)
      load[0] |=> mon_q[0] == $past(word[0]);
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx monitor not loaded");

  property p_rx_load;
    @(posedge core_clk) disable iff (!rst_sync_n)
      load[1] |=> mon_q[1] == $past(word[1]);
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("rx monitor not loaded");

  property p_tx_order;
    @(posedge core_clk) disable iff (!rst_sync_n)
      load[0] |=> mon_q[0][0] == $past(g_dir[0].s2_q[0]);
  endproperty
  a_tx_order: assert property (p_tx_order) else $error("tx last bit not in bit 0");

  property p_rx_order;
    @(posedge core_clk) disable iff (!rst_sync_n)
      load[1] |=> mon_q[1][7:1] == $past(g_dir[1].shift_q[6:0]);
  endproperty
  a_rx_order: assert property (p_rx_order) else $error("rx bit order wrong");

  property p_frame_start;
    @(posedge core_clk) disable iff (!rst_sync_n)
      stb[0] && g_dir[0].s2_q[2] |=> cnt_q[0] == 8'h01;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame sync not bit 0");

  property p_hold;
    @(posedge core_clk) disable iff (!rst_sync_n)
      !load[1] |=> $stable(mon_q[1]);
  endproperty
  a_hold: assert property (p_hold) else $error("rx monitor changed mid octet");

  property p_indep;
    @(posedge core_clk) disable iff (!rst_sync_n)
      stb[0] && !stb[1] |=> $stable(cnt_q[1]);
  endproperty
  a_indep: assert property (p_indep) else $error("tx strobe disturbed rx");

  property p_read;
    @(posedge core_clk) disable iff (!rst_sync_n)
      bus_rd && bus_addr == ds0_monitor_pkg::RX_MON_DATA_ADDR |=> bus_rdata == $past(mon_q[1]);
  endproperty
  a_read: assert property (p_read) else $error("rx monitor read wrong");

  c_tx_load: cover property (@(posedge core_clk) disable iff (!rst_sync_n) load[0]);
  c_rx_load: cover property (@(posedge core_clk) disable iff (!rst_sync_n) load[1]);
  c_both:    cover property (@(posedge core_clk) disable iff (!rst_sync_n) load[0] && load[1]);

endmodule : ds0_channel_monitor

`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ****************************************************************
  // Stimulus and checks
  // ****************************************************************
  logic        core_clk, reset_n, bus_wr, bus_rd;
  logic [7:0]  bus_addr, bus_wdata, bus_rdata, got;
  logic        tx_d, tx_s, tx_f, rx_d, rx_s, rx_f;
  logic        rle, lle, aie, lrb;
  int          err_count, cmp_count;
  // Rows: transmit timeslot, receive timeslot, frame data key
  logic [17:0] rows [3] = '{{5'h05, 5'h0E, 8'h3C}, {5'h00, 5'h1F, 8'h5A}, {5'h1F, 5'h01, 8'h96}};
  logic [7:0]  addrs [5] = '{8'h49, 8'hA8, 8'hAA, 8'hAB, 8'h00};

  ds0_channel_monitor i_dut (.core_clk(core_clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .tx_line_data(tx_d), .tx_bit_strobe(tx_s),
    .tx_frame_sync(tx_f), .rx_line_data(rx_d), .rx_bit_strobe(rx_s), .rx_frame_sync(rx_f),
    .remote_loop_enable(rle), .local_loop_enable(lle), .line_alarm_indication_enable(aie),
    .line_interface_reset_bit(lrb));

  // Octet carried in a timeslot; direction flips bit 0 so the two paths differ
  function automatic logic [7:0] pat(input logic d, input logic [4:0] s, input logic [7:0] k);
    return {s, 2'h0, d} ^ k;
  endfunction : pat

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    step();
    bus_wr = 1'b0;
    step();
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus_addr = a;
    bus_rd = 1'b1;
    step();
    bus_rd = 1'b0;
    step();
    got = bus_rdata;
  endtask : rd

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Strobes stay 4 clocks high and 4 low, above the 3-clock minimum
  task automatic frame(input logic [7:0] k);
    logic [7:0] tb;
    logic [7:0] rb;
    for (int b = 0; b < 256; b++) begin
      tb = pat(1'b0, b[7:3], k);
      rb = pat(1'b1, b[7:3], k);
      tx_f = (b == 0);
      rx_f = (b == 0);
      tx_d = tb[7 - b[2:0]];
      rx_d = rb[7 - b[2:0]];
      tx_s = 1'b1;
      rx_s = 1'b1;
      repeat (4) step();
      tx_s = 1'b0;
      rx_s = 1'b0;
      repeat (4) step();
    end
    tx_f = 1'b0;
    rx_f = 1'b0;
    repeat (6) step();
  endtask : frame

  task automatic close_out();
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Five frames of about 2100 clocks each plus register traffic and a reset
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    close_out();
  end

  initial begin
    {reset_n, bus_wr, bus_rd, tx_d, tx_s, tx_f, rx_d, rx_s, rx_f} = '0;
    bus_addr = 8'h00;
    bus_wdata = 8'h00;
    repeat (3) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (5) step();
    foreach (addrs[i]) begin
      rd(addrs[i]);
      chk("reset value", 8'h00, got);
    end
    chk("control outputs", 8'h00, {4'h0, rle, lle, aie, lrb});
    wr(ds0_monitor_pkg::TX_MON_SELECT_ADDR, 8'hE0);
    wr(ds0_monitor_pkg::RX_MON_SELECT_ADDR, 8'h80);
    chk("control outputs", 8'h0F, {4'h0, rle, lle, aie, lrb});
    wr(ds0_monitor_pkg::TX_MON_DATA_ADDR, 8'hFF);
    wr(ds0_monitor_pkg::RX_MON_DATA_ADDR, 8'hFF);
    wr(8'h00, 8'hFF);
    foreach (addrs[i]) begin
      rd(addrs[i]);
      chk("after writes", (i == 1) ? 8'hE0 : ((i == 2) ? 8'h80 : 8'h00), got);
    end
    for (int r = 0; r < 4; r++) begin
      wr(ds0_monitor_pkg::TX_MON_SELECT_ADDR, {3'h0, rows[r % 3][17:13]});
      wr(ds0_monitor_pkg::RX_MON_SELECT_ADDR, {3'h0, rows[r % 3][12:8]});
      frame(rows[r % 3][7:0] ^ {8{r == 3}});
      rd(ds0_monitor_pkg::TX_MON_DATA_ADDR);
      chk("tx monitor", pat(1'b0, rows[r % 3][17:13], rows[r % 3][7:0] ^ {8{r == 3}}), got);
      rd(ds0_monitor_pkg::RX_MON_DATA_ADDR);
      chk("rx monitor", pat(1'b1, rows[r % 3][12:8], rows[r % 3][7:0] ^ {8{r == 3}}), got);
    end
    // Same timeslot both ways, so both loads land together; upper select bits must not steer
    wr(ds0_monitor_pkg::TX_MON_SELECT_ADDR, 8'hEA);
    wr(ds0_monitor_pkg::RX_MON_SELECT_ADDR, 8'h8A);
    frame(8'hC3);
    rd(ds0_monitor_pkg::TX_MON_DATA_ADDR);
    chk("tx monitor", pat(1'b0, 5'h0A, 8'hC3), got);
    rd(ds0_monitor_pkg::RX_MON_DATA_ADDR);
    chk("rx monitor", pat(1'b1, 5'h0A, 8'hC3), got);
    chk("control outputs", 8'h0F, {4'h0, rle, lle, aie, lrb});
    // Reset in mid-run must clear selectors and monitors alike
    reset_n = 1'b0;
    repeat (2) step();
    reset_n = 1'b1;
    repeat (5) step();
    foreach (addrs[i]) begin
      rd(addrs[i]);
      chk("reset value", 8'h00, got);
    end
    chk("control outputs", 8'h00, {4'h0, rle, lle, aie, lrb});
    close_out();
  end
endmodule : testbench
`default_nettype wire
